// File: design/dcc_top.sv
`include "dcc_defs.svh"
module dcc_top (
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_b,
    // register port
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr_en,
    output logic      [7:0] o_rdata,
    // neighbouring controls
    input  wire logic       i_dll_en,
    input  wire logic       i_warn_clear,
    // live hardware conditions
    input  wire logic       i_dll_lock,
    input  wire logic       i_dll_warn_start,
    input  wire logic       i_dll_warn_end,
    input  wire logic       i_data_clock_present,
    // capture controls
    output logic            o_low_rate_capture_sel,
    output logic            o_delay_line_mode_sel,
    output logic            o_dll_active,
    output logic            o_delay_line_active,
    output logic      [7:0] o_tuning,
    output logic      [3:0] o_capture_trim,
    // clock receivers
    output logic            o_converter_clock_duty_fix_en,
    output logic            o_converter_clock_cross_ctrl_en,
    output logic      [4:0] o_converter_clock_cross_level,
    output logic            o_reference_clock_duty_fix_en,
    output logic            o_reference_clock_cross_ctrl_en,
    output logic      [4:0] o_reference_clock_cross_level,
    // pll
    output logic            o_pll_enable,
    output logic            o_pll_band_manual,
    output logic      [5:0] o_pll_manual_band
);
    logic [1:0] rst_sync;
    logic       rst_b;
    logic [7:0] data_ctrl_reserved_tuning;
    logic [7:0] data_capture_mode_ctrl;
    logic [7:0] converter_clock_receiver_ctrl;
    logic [7:0] reference_clock_receiver_ctrl;
    logic [7:0] pll_enable_band_ctrl;
    logic [7:0] next_tuning;
    logic [7:0] next_capmode;
    logic [7:0] next_convclk;
    logic [7:0] next_reference_clock;
    logic [7:0] next_pll;
    logic [7:0] next_rdata;
    logic [7:0] status;

    // ***********************************************
    // address decode
    // ***********************************************
    function automatic logic reg_writable(input logic [7:0] addr);
        return (addr == `DCC_OFS_TUNING) || (addr == `DCC_OFS_CAPMODE)
            || (addr == `DCC_OFS_CONVCLK) || (addr == `DCC_OFS_REFERENCE_CLOCK)
            || (addr == `DCC_OFS_PLL);
    endfunction

    // ***********************************************
    // reset release
    // ***********************************************
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_b = rst_sync[1];

    // ***********************************************
    // register writes
    // ***********************************************
    always_comb begin
        next_tuning  = data_ctrl_reserved_tuning;
        next_capmode = data_capture_mode_ctrl;
        next_convclk = converter_clock_receiver_ctrl;
        next_reference_clock  = reference_clock_receiver_ctrl;
        next_pll     = pll_enable_band_ctrl;
        if (i_wr_en) begin
            unique case (i_addr)
                `DCC_OFS_TUNING:  next_tuning  = i_wdata;
                `DCC_OFS_CAPMODE: next_capmode = i_wdata;
                `DCC_OFS_CONVCLK: next_convclk = i_wdata;
                `DCC_OFS_REFERENCE_CLOCK:  next_reference_clock  = i_wdata;
                `DCC_OFS_PLL:     next_pll     = i_wdata;
                default: begin
                    next_tuning = data_ctrl_reserved_tuning;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            data_ctrl_reserved_tuning     <= `DCC_RST_TUNING;
            data_capture_mode_ctrl        <= `DCC_RST_CAPMODE;
            converter_clock_receiver_ctrl <= `DCC_RST_CONVCLK;
            reference_clock_receiver_ctrl <= `DCC_RST_REFERENCE_CLOCK;
            pll_enable_band_ctrl          <= `DCC_RST_PLL;
        end else begin
            data_ctrl_reserved_tuning     <= next_tuning;
            data_capture_mode_ctrl        <= next_capmode;
            converter_clock_receiver_ctrl <= next_convclk;
            reference_clock_receiver_ctrl <= next_reference_clock;
            pll_enable_band_ctrl          <= next_pll;
        end
    end

    // ***********************************************
    // status
    // ***********************************************
    dcc_status u_status (
        .i_sys_clk      (i_sys_clk),
        .i_rst_b        (rst_b),
        .i_lock         (i_dll_lock),
        .i_warn_start   (i_dll_warn_start),
        .i_warn_end     (i_dll_warn_end),
        .i_dclk_present (i_data_clock_present),
        .i_dll_en       (i_dll_en),
        .i_dline_mode   (data_capture_mode_ctrl[`DCC_BIT_DLINE_MODE]),
        .i_warn_clear   (i_warn_clear),
        .o_status       (status)
    );

    // ***********************************************
    // read back
    // ***********************************************
    always_comb begin
        unique case (i_addr)
            `DCC_OFS_TUNING:  next_rdata = data_ctrl_reserved_tuning;
            `DCC_OFS_CAPMODE: next_rdata = data_capture_mode_ctrl;
            `DCC_OFS_STATUS:  next_rdata = status;
            `DCC_OFS_CONVCLK: next_rdata = converter_clock_receiver_ctrl;
            `DCC_OFS_REFERENCE_CLOCK:  next_rdata = reference_clock_receiver_ctrl;
            `DCC_OFS_PLL:     next_rdata = pll_enable_band_ctrl;
            default:          next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= next_rdata;
        end
    end

    // ***********************************************
    // control outputs
    // ***********************************************
    assign o_low_rate_capture_sel = data_capture_mode_ctrl[`DCC_BIT_LOW_RATE];
    assign o_delay_line_mode_sel  = data_capture_mode_ctrl[`DCC_BIT_DLINE_MODE];
    assign o_dll_active           = !o_delay_line_mode_sel;
    assign o_delay_line_active    = o_delay_line_mode_sel;
    assign o_tuning               = data_ctrl_reserved_tuning;
    assign o_capture_trim         = data_capture_mode_ctrl[3:0];

    assign o_converter_clock_duty_fix_en   =
        converter_clock_receiver_ctrl[`DCC_BIT_DUTY_EN];
    assign o_converter_clock_cross_ctrl_en =
        converter_clock_receiver_ctrl[`DCC_BIT_CROSS_EN];
    assign o_converter_clock_cross_level   = converter_clock_receiver_ctrl[4:0];
    assign o_reference_clock_duty_fix_en   =
        reference_clock_receiver_ctrl[`DCC_BIT_DUTY_EN];
    assign o_reference_clock_cross_ctrl_en =
        reference_clock_receiver_ctrl[`DCC_BIT_CROSS_EN];
    assign o_reference_clock_cross_level   = reference_clock_receiver_ctrl[4:0];

    assign o_pll_enable      = pll_enable_band_ctrl[`DCC_BIT_PLL_EN];
    assign o_pll_band_manual = pll_enable_band_ctrl[`DCC_BIT_BAND_MAN];
    assign o_pll_manual_band = pll_enable_band_ctrl[5:0];

    // ***********************************************
    // checks
    // ***********************************************
    sequence s_pll_write;
        rst_b && i_wr_en && i_addr == `DCC_OFS_PLL;
    endsequence
    sequence s_capmode_write;
        rst_b && i_wr_en && i_addr == `DCC_OFS_CAPMODE;
    endsequence
    sequence s_convclk_write;
        rst_b && i_wr_en && i_addr == `DCC_OFS_CONVCLK;
    endsequence
    sequence s_reference_clock_write;
        rst_b && i_wr_en && i_addr == `DCC_OFS_REFERENCE_CLOCK;
    endsequence

    a_pll_enable_wr: assert property (@(posedge i_sys_clk) disable iff (!rst_b)
        s_pll_write |=> o_pll_enable == $past(i_wdata[`DCC_BIT_PLL_EN]))
        else $error("pll enable not written");
    a_band_mode_wr: assert property (@(posedge i_sys_clk) disable iff (!rst_b)
        s_pll_write |=> o_pll_band_manual == $past(i_wdata[`DCC_BIT_BAND_MAN])
            && o_pll_manual_band == $past(i_wdata[5:0]))
        else $error("band fields not written");
    a_mode_exclusive: assert property (@(posedge i_sys_clk) disable iff (!rst_b)
        s_capmode_write |=> o_delay_line_active == $past(i_wdata[`DCC_BIT_DLINE_MODE])
            && o_dll_active == !$past(i_wdata[`DCC_BIT_DLINE_MODE]))
        else $error("capture modes overlap");
    a_conv_fields_wr: assert property (@(posedge i_sys_clk) disable iff (!rst_b)
        s_convclk_write |=> o_converter_clock_duty_fix_en == $past(i_wdata[`DCC_BIT_DUTY_EN])
            && o_converter_clock_cross_ctrl_en == $past(i_wdata[`DCC_BIT_CROSS_EN])
            && o_converter_clock_cross_level == $past(i_wdata[4:0]))
        else $error("converter clock fields not written");
    a_ref_fields_wr: assert property (@(posedge i_sys_clk) disable iff (!rst_b)
        s_reference_clock_write |=> o_reference_clock_duty_fix_en == $past(i_wdata[`DCC_BIT_DUTY_EN])
            && o_reference_clock_cross_ctrl_en == $past(i_wdata[`DCC_BIT_CROSS_EN])
            && o_reference_clock_cross_level == $past(i_wdata[4:0]))
        else $error("reference clock fields not written");
    a_conv_reset: assert property (@(posedge i_sys_clk)
        $rose(rst_b) |-> converter_clock_receiver_ctrl == `DCC_RST_CONVCLK
            && reference_clock_receiver_ctrl == `DCC_RST_REFERENCE_CLOCK)
        else $error("receiver reset values wrong");
    a_status_ro: assert property (@(posedge i_sys_clk) disable iff (!rst_b)
        rst_b && i_wr_en && i_addr == `DCC_OFS_STATUS
            |=> $stable(pll_enable_band_ctrl) && $stable(data_capture_mode_ctrl))
        else $error("status write had side effect");
    a_unmapped_wr: assert property (@(posedge i_sys_clk) disable iff (!rst_b)
        rst_b && i_wr_en && !reg_writable(i_addr)
            |=> $stable({data_ctrl_reserved_tuning, data_capture_mode_ctrl,
                converter_clock_receiver_ctrl, reference_clock_receiver_ctrl,
                pll_enable_band_ctrl}))
        else $error("unmapped write had side effect");
    a_status_read: assert property (@(posedge i_sys_clk) disable iff (!rst_b)
        rst_b && i_addr == `DCC_OFS_STATUS |=> o_rdata == $past(status))
        else $error("status readback wrong");
    a_unmapped_read: assert property (@(posedge i_sys_clk) disable iff (!rst_b)
        rst_b && !reg_writable(i_addr) && i_addr != `DCC_OFS_STATUS |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule

// File: design/dcc_defs.svh
// Summary of operation
// - delay-line bit selects DLL or delay line
// - status shows lock and three warnings
// - status bit 2 shows data clock present
// - status bit 0 shows loop tracking
// - converter clock register resets to 0xFF
// - converter crosspoint five-bit two's complement level
// - reference clock register resets to 0x5F
// - reference crosspoint level in bits 4:0
// - PLL enable bit 7, resets off
// - bit 6 picks auto or manual band
// - six-bit manual band field, 64 bands
// - warning clear empties three warning bits; a warning arriving in the same cycle wins
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH
// ***********************************************
// offsets
// ***********************************************
`define DCC_OFS_TUNING     8'h0C
`define DCC_OFS_CAPMODE    8'h0D
`define DCC_OFS_STATUS     8'h0E
`define DCC_OFS_CONVCLK    8'h10
`define DCC_OFS_REFERENCE_CLOCK     8'h11
`define DCC_OFS_PLL        8'h12
// ***********************************************
// reset values
// ***********************************************
`define DCC_RST_TUNING     8'h64
`define DCC_RST_CAPMODE    8'h06
`define DCC_RST_CONVCLK    8'hFF
`define DCC_RST_REFERENCE_CLOCK     8'h5F
`define DCC_RST_PLL        8'h00
// ***********************************************
// field positions
// ***********************************************
`define DCC_BIT_LOW_RATE   7
`define DCC_BIT_DLINE_MODE 4
`define DCC_BIT_LOCK       7
`define DCC_BIT_WARN       6
`define DCC_BIT_WARN_START 5
`define DCC_BIT_WARN_END   4
`define DCC_BIT_DCLK_ON    2
`define DCC_BIT_TRACKING   0
`define DCC_BIT_DUTY_EN    7
`define DCC_BIT_CROSS_EN   5
`define DCC_BIT_PLL_EN     7
`define DCC_BIT_BAND_MAN   6
`endif

// File: design/dcc_pkg.sv
package dcc_pkg;
    typedef enum logic [0:0] {
        DCC_CAP_DLL   = 1'b0,
        DCC_CAP_DLINE = 1'b1
    } dcc_cap_mode_t;
    typedef enum logic [0:0] {
        DCC_BAND_AUTO   = 1'b0,
        DCC_BAND_MANUAL = 1'b1
    } dcc_band_mode_t;
endpackage

// File: design/dcc_status.sv
`include "dcc_defs.svh"
module dcc_status (
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_b,
    // live conditions
    input  wire logic       i_lock,
    input  wire logic       i_warn_start,
    input  wire logic       i_warn_end,
    input  wire logic       i_dclk_present,
    input  wire logic       i_dll_en,
    input  wire logic       i_dline_mode,
    input  wire logic       i_warn_clear,
    // status byte
    output logic      [7:0] o_status
);
    logic warn_start;
    logic warn_end;
    logic next_warn_start;
    logic next_warn_end;
    logic tracking;

    // ***********************************************
    // sticky warnings
    // ***********************************************
    always_comb begin
        next_warn_start = warn_start;
        next_warn_end   = warn_end;
        if (i_warn_clear) begin
            next_warn_start = 1'b0;
            next_warn_end   = 1'b0;
        end
        if (i_warn_start) begin
            next_warn_start = 1'b1;
        end
        if (i_warn_end) begin
            next_warn_end = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            warn_start <= 1'b0;
            warn_end   <= 1'b0;
        end else begin
            warn_start <= next_warn_start;
            warn_end   <= next_warn_end;
        end
    end

    assign tracking = i_dll_en && (i_dline_mode == dcc_pkg::DCC_CAP_DLL);

    // ***********************************************
    // status assembly
    // ***********************************************
    always_comb begin
        o_status                      = 8'h00;
        o_status[`DCC_BIT_LOCK]       = i_lock && tracking;
        o_status[`DCC_BIT_WARN]       = warn_start || warn_end;
        o_status[`DCC_BIT_WARN_START] = warn_start;
        o_status[`DCC_BIT_WARN_END]   = warn_end;
        o_status[`DCC_BIT_DCLK_ON]    = i_dclk_present;
        o_status[`DCC_BIT_TRACKING]   = tracking;
    end

    a_warn_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_rst_b && i_warn_clear && !i_warn_start && !i_warn_end |=> o_status[6:4] == 3'h0)
        else $error("warning bits not cleared");
    a_warn_sticky: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_rst_b && i_warn_start |=> o_status[`DCC_BIT_WARN_START] && o_status[`DCC_BIT_WARN])
        else $error("start warning not held");
    a_dclk_live: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        o_status[`DCC_BIT_DCLK_ON] == i_dclk_present)
        else $error("data clock present not live");
    a_track_mode: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_dline_mode |-> !o_status[`DCC_BIT_TRACKING])
        else $error("tracking in delay-line mode");
endmodule

// File: verification/test_dcc_top.sv
module test_dcc_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ***********************************************
    // stimulus and observed signals
    // ***********************************************
    logic       i_sys_clk            = 1'b0;
    logic       i_rst_b              = 1'b0;
    logic [7:0] i_addr               = 8'h00;
    logic [7:0] i_wdata              = 8'h00;
    logic       i_wr_en              = 1'b0;
    logic       i_dll_en             = 1'b0;
    logic       i_warn_clear         = 1'b0;
    logic       i_dll_lock           = 1'b0;
    logic       i_dll_warn_start     = 1'b0;
    logic       i_dll_warn_end       = 1'b0;
    logic       i_data_clock_present = 1'b0;
    logic [7:0] o_rdata, o_tuning;
    logic [3:0] o_capture_trim;
    logic       o_low_rate_capture_sel, o_delay_line_mode_sel;
    logic       o_dll_active, o_delay_line_active;
    logic       o_converter_clock_duty_fix_en, o_converter_clock_cross_ctrl_en;
    logic [4:0] o_converter_clock_cross_level, o_reference_clock_cross_level;
    logic       o_reference_clock_duty_fix_en, o_reference_clock_cross_ctrl_en;
    logic       o_pll_enable, o_pll_band_manual;
    logic [5:0] o_pll_manual_band;
    logic [7:0] cap_byte, conv_byte, ref_byte, pll_byte;
    int         bad_count            = 0;
    int         num_checks           = 0;
    localparam logic [7:0] reg_ofs [5] = '{8'h0C, 8'h0D, 8'h10, 8'h11, 8'h12};
    localparam logic [7:0] reg_rst [5] = '{8'h64, 8'h06, 8'hFF, 8'h5F, 8'h00};
    localparam logic [7:0] wr_ofs [7] = '{8'h12, 8'h12, 8'h12, 8'h10, 8'h11, 8'h0D, 8'h0C};
    localparam logic [7:0] wr_val [7] = '{8'hFF, 8'h40, 8'h80, 8'h4F, 8'hFF, 8'h96, 8'h64};

    dcc_top dcc_top_i (
        .i_sys_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr_en, .o_rdata, .i_dll_en,
        .i_warn_clear, .i_dll_lock, .i_dll_warn_start, .i_dll_warn_end,
        .i_data_clock_present, .o_low_rate_capture_sel, .o_delay_line_mode_sel,
        .o_dll_active, .o_delay_line_active, .o_tuning, .o_capture_trim,
        .o_converter_clock_duty_fix_en, .o_converter_clock_cross_ctrl_en,
        .o_converter_clock_cross_level, .o_reference_clock_duty_fix_en,
        .o_reference_clock_cross_ctrl_en, .o_reference_clock_cross_level,
        .o_pll_enable, .o_pll_band_manual, .o_pll_manual_band
    );

    // ***********************************************
    // clock and output images
    // ***********************************************
    always #10 i_sys_clk = ~i_sys_clk;
    assign cap_byte  = {o_low_rate_capture_sel, 2'b00, o_delay_line_mode_sel, o_capture_trim};
    assign conv_byte = {o_converter_clock_duty_fix_en, 1'b1, o_converter_clock_cross_ctrl_en,
                        o_converter_clock_cross_level};
    assign ref_byte  = {o_reference_clock_duty_fix_en, 1'b1, o_reference_clock_cross_ctrl_en,
                        o_reference_clock_cross_level};
    assign pll_byte  = {o_pll_enable, o_pll_band_manual, o_pll_manual_band};

    // ***********************************************
    // helpers
    // ***********************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] mirror(input logic [7:0] a);
        case (a)
            8'h0C: return o_tuning;
            8'h0D: return cap_byte;
            8'h10: return conv_byte;
            8'h11: return ref_byte;
            default: return pll_byte;
        endcase
    endfunction

    task automatic do_reset();
        i_rst_b = 1'b0;
        repeat (3) @(negedge i_sys_clk);
        i_rst_b = 1'b1;
        repeat (3) @(negedge i_sys_clk);
    endtask

    // strobe stays high so writes can follow back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_addr  = a;
        i_wdata = d;
        i_wr_en = 1'b1;
        @(negedge i_sys_clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        i_wr_en = 1'b0;
        i_addr  = a;
        repeat (2) @(negedge i_sys_clk);
        chk(o_rdata, exp);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge i_sys_clk);
        s = 1'b0;
    endtask

    // ***********************************************
    // scenarios
    // ***********************************************
    task automatic t_reset_values();
        for (int k = 0; k < 5; k++) begin
            rd_chk(reg_ofs[k], reg_rst[k]);
            chk(mirror(reg_ofs[k]), reg_rst[k]);
        end
    endtask

    task automatic t_fields();
        for (int k = 0; k < 7; k++) begin
            wr(wr_ofs[k], wr_val[k]);
            rd_chk(wr_ofs[k], wr_val[k]);
            chk(mirror(wr_ofs[k]), wr_val[k]);
        end
        chk({6'h00, o_dll_active, o_delay_line_active}, 8'h01);
        wr(8'h12, 8'h81);
        wr(8'h10, 8'h5F);
        wr(8'h0D, 8'h06);
        rd_chk(8'h12, 8'h81);
        rd_chk(8'h10, 8'h5F);
        chk({6'h00, o_dll_active, o_delay_line_active}, 8'h02);
    endtask

    task automatic t_status();
        i_data_clock_present = 1'b1;
        i_dll_lock           = 1'b1;
        i_dll_en             = 1'b1;
        rd_chk(8'h0E, 8'h85);
        wr(8'h0E, 8'h00);
        rd_chk(8'h0E, 8'h85);
        i_dll_en = 1'b0;
        rd_chk(8'h0E, 8'h04);
        i_dll_en = 1'b1;
        wr(8'h0D, 8'h16);
        rd_chk(8'h0E, 8'h04);
        wr(8'h0D, 8'h06);
        i_data_clock_present = 1'b0;
        rd_chk(8'h0E, 8'h81);
    endtask

    task automatic t_warn();
        pulse(i_dll_warn_start);
        rd_chk(8'h0E, 8'hE1);
        pulse(i_warn_clear);
        rd_chk(8'h0E, 8'h81);
        pulse(i_dll_warn_end);
        rd_chk(8'h0E, 8'hD1);
        rd_chk(8'h0E, 8'hD1);
        pulse(i_warn_clear);
        rd_chk(8'h0E, 8'h81);
        i_dll_warn_start = 1'b1;
        i_warn_clear     = 1'b1;
        @(negedge i_sys_clk);
        i_dll_warn_start = 1'b0;
        i_warn_clear     = 1'b0;
        rd_chk(8'h0E, 8'hE1);
        pulse(i_warn_clear);
        rd_chk(8'h0E, 8'h81);
    endtask

    task automatic t_unmapped();
        wr(8'h0F, 8'hAA);
        wr(8'h13, 8'h00);
        rd_chk(8'h0F, 8'h00);
        rd_chk(8'h13, 8'h00);
        rd_chk(8'h10, 8'h5F);
        rd_chk(8'h12, 8'h81);
    endtask

    // ***********************************************
    // main sequence and hang guard
    // ***********************************************
    initial begin
        do_reset();
        t_reset_values();
        t_fields();
        t_status();
        t_warn();
        t_unmapped();
        do_reset();
        t_reset_values();
        close_out();
    end

    initial begin
        repeat (5000) @(negedge i_sys_clk);
        bad_count++;
        close_out();
    end
endmodule
